// ===== hdl/mrm_map.svh
// register numbers, field positions and codes of the motor register front end
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef MRM_MAP_SVH
`define MRM_MAP_SVH
`define MRM_CLASS_REG 16'h0064
`define MRM_MSG_LEN 8'h04
`define MRM_REG_MODE 8'h02
`define MRM_REG_POS_SP 8'h03
`define MRM_REG_VEL 8'h05
`define MRM_REG_ACC 8'h06
`define MRM_REG_TRQ 8'h07
`define MRM_REG_POS_ACT 8'h0a
`define MRM_REG_VEL_ACT 8'h0c
`define MRM_REG_LOAD 8'h10
`define MRM_REG_FERR 8'h14
`define MRM_REG_STATUS 8'h23
`define MRM_REG_CMD 8'hd3
`define MRM_CMD_SAVE 32'h0000_0002
`define MRM_MODE_PASSIVE 32'h0000_0000
`define MRM_MODE_VEL 32'h0000_0001
`define MRM_MODE_POS 32'h0000_0002
`define MRM_ST_INPOS 4
`define MRM_ST_ACCEL 5
`define MRM_ST_DECEL 6
`define MRM_ST_ERR_LSB 8
`define MRM_TRQ_MAX 32'h0000_03ff
`define MRM_TRQ_FULL 10'h3ff
`define MRM_CFG_LAST 3'h4
`define MRM_CFG_MODE 3'h0
`define MRM_CFG_VEL 3'h1
`define MRM_CFG_ACC 3'h2
`define MRM_CFG_TRQ 3'h3
`define MRM_CFG_POS 3'h4
`define MRM_CYC_N 5
`endif

// ===== hdl/mrm_pkg.sv
// types of the motor register front end
`default_nettype none
`include "mrm_map.svh"
package mrm_pkg;
	typedef enum logic [2:0] {
		ST_LOAD_REQ = 3'b000,
		ST_LOAD_WAIT = 3'b001,
		ST_RUN = 3'b010,
		ST_SAVE_REQ = 3'b011,
		ST_SAVE_WAIT = 3'b100,
		ST_RESET = 3'b101
	} mrm_fsm_t;

	typedef struct packed {
		mrm_fsm_t fsm;
		logic [2:0] idx;
		logic [31:0] mode;
		logic [31:0] vel;
		logic [31:0] acc;
		logic [31:0] trq;
		logic [31:0] pos;
		logic [7:0] err;
		logic rsp_valid;
		logic rsp_error;
		logic [31:0] rsp_data;
		logic [`MRM_CYC_N-1:0][31:0] cyc_rd;
		logic fl_rd;
		logic fl_wr;
		logic [2:0] fl_addr;
		logic [31:0] fl_wdata;
		logic sys_rst;
		logic fwd_valid;
		logic [7:0] fwd_data;
		logic [9:0] trq_out;
	} mrm_top_st_t;

	typedef struct packed {
		logic signed [31:0] pos;
		logic signed [31:0] vel;
		logic signed [31:0] ferr;
		logic en;
		logic inpos;
		logic accel;
		logic decel;
	} mrm_mot_st_t;
endpackage : mrm_pkg
`default_nettype wire

// ===== hdl/mrm_motion_if.sv
// carrier between the register front end and the motion profiler
`timescale 1ns/1ps
`default_nettype none
interface mrm_motion_if;
	logic enable;
	logic [31:0] mode;
	logic [31:0] vel_sp;
	logic [31:0] acc_sp;
	logic [31:0] pos_sp;
	logic [31:0] pos_act;
	logic [31:0] vel_act;
	logic [31:0] ferr;
	logic in_pos;
	logic accel;
	logic decel;
	logic drive_en;
	modport ctl (output enable, mode, vel_sp, acc_sp, pos_sp,
		input pos_act, vel_act, ferr, in_pos, accel, decel, drive_en);
	modport mot (input enable, mode, vel_sp, acc_sp, pos_sp,
		output pos_act, vel_act, ferr, in_pos, accel, decel, drive_en);
endinterface : mrm_motion_if
`default_nettype wire

// ===== hdl/mrm_motion.sv
// velocity ramp and position tracking profiler
`timescale 1ns/1ps
`default_nettype none
`include "mrm_map.svh"
module mrm_motion (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// setpoints in, motion state out
	mrm_motion_if.mot m
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	mrm_pkg::mrm_mot_st_t q, n;
	logic signed [31:0] tgt, dv, step, perr, vsp, asp, lead;

	function automatic logic signed [31:0] mag(input logic signed [31:0] v);
		mag = (v < 0) ? -v : v;
	endfunction : mag

	// -------------------------------------------------------------------
	// profile step: one sample per clock, setpoints taken as raw counts
	// -------------------------------------------------------------------
	always_comb begin
		n = q;
		vsp = $signed(m.vel_sp); // raw count, no scaling
		asp = $signed(m.acc_sp); // raw count, no scaling
		perr = $signed(m.pos_sp) - q.pos;
		// error left once this sample's motion lands; aiming at perr hunts
		lead = perr - q.vel;
		tgt = '0;
		dv = '0;
		step = '0;
		n.ferr = perr;
		n.en = m.enable; // passive mode de-energizes
		if (!m.enable) begin
			n.vel = '0; // axle free, no stored speed kept
			n.accel = 1'b0;
			n.decel = 1'b0;
			n.inpos = 1'b0;
		end else begin
			if (m.mode == `MRM_MODE_VEL) begin
				tgt = vsp;
			end else if (m.mode == `MRM_MODE_POS) begin
				// clamp toward target so the approach slows on its own
				tgt = (lead > vsp) ? vsp : ((lead < -vsp) ? -vsp : lead);
			end
			dv = tgt - q.vel;
			step = (dv > asp) ? asp : ((dv < -asp) ? -asp : dv);
			n.vel = q.vel + step;
			n.pos = q.pos + q.vel;
			n.accel = mag(n.vel) > mag(q.vel);
			n.decel = mag(n.vel) < mag(q.vel);
			n.inpos = (m.mode == `MRM_MODE_POS) && (n.pos == $signed(m.pos_sp))
				&& (n.vel == 0);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// outputs straight from the state flops
	assign m.pos_act = q.pos;
	assign m.vel_act = q.vel;
	assign m.ferr = q.ferr;
	assign m.in_pos = q.inpos;
	assign m.accel = q.accel;
	assign m.decel = q.decel;
	assign m.drive_en = q.en;

	AST_PASSIVE_OFF: assert property (
		!m.enable |=> !m.drive_en && q.vel == 0)
		else $error("drive stayed energized in passive mode");
	AST_VEL_RAMPS: assert property (
		(m.enable && m.mode == `MRM_MODE_VEL
		&& q.vel != $signed(m.vel_sp) && m.acc_sp != 0)
		|=> q.vel != $past(q.vel))
		else $error("velocity did not ramp toward setpoint");
endmodule : mrm_motion
`default_nettype wire

// ===== hdl/mrm_top.sv
// motor register front end: messages, cyclic words, flash set, mode control
`timescale 1ns/1ps
`default_nettype none
`include "mrm_map.svh"
module mrm_top #(
	parameter logic [`MRM_CYC_N*8-1:0] CYC_WR_MAP = 40'h02_0706_0503,
	parameter logic [`MRM_CYC_N*8-1:0] CYC_RD_MAP = 40'h10_140c_230a
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// acyclic message request
	input wire logic msg_valid_i,
	input wire logic msg_write_i,
	input wire logic [15:0] msg_class_i,
	input wire logic [15:0] msg_instance_i,
	input wire logic [7:0] msg_len_i,
	input wire logic [31:0] msg_wdata_i,
	// acyclic message answer
	output logic rsp_valid_o,
	output logic rsp_error_o,
	output logic [31:0] rsp_rdata_o,
	// cyclic assembly words
	input wire logic cyc_wr_valid_i,
	input wire logic [`MRM_CYC_N*32-1:0] cyc_wr_data_i,
	output logic [`MRM_CYC_N*32-1:0] cyc_rd_data_o,
	// drive side
	input wire logic [7:0] fault_i,
	input wire logic [31:0] motor_load_i,
	output logic drive_enable_o,
	output logic [31:0] velocity_cmd_o,
	output logic [9:0] torque_limit_o,
	// configuration flash
	output logic flash_rd_o,
	output logic flash_wr_o,
	output logic [2:0] flash_addr_o,
	output logic [31:0] flash_wdata_o,
	input wire logic [31:0] flash_rdata_i,
	input wire logic flash_ack_i,
	output logic sys_reset_req_o,
	// switch: port one in, port two out
	input wire logic p1_rx_valid_i,
	input wire logic [7:0] p1_rx_data_i,
	input wire logic p1_rx_local_i,
	output logic p2_tx_valid_o,
	output logic [7:0] p2_tx_data_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	mrm_pkg::mrm_top_st_t q, n;
	mrm_motion_if m ();
	logic [31:0] status_w;
	logic [`MRM_CYC_N-1:0][31:0] cyc_rd_w;
	logic msg_ok, msg_hit, msg_save;
	logic [32:0] msg_rd;

	// ---------------------------------------------------------------
	// register helpers
	// ---------------------------------------------------------------
	// read view: bit 32 marks an existing readable register
	function automatic logic [32:0] rd_reg(input logic [7:0] num);
		unique case (num)
			`MRM_REG_MODE: rd_reg = {1'b1, q.mode};
			`MRM_REG_POS_SP: rd_reg = {1'b1, q.pos};
			`MRM_REG_VEL: rd_reg = {1'b1, q.vel};
			`MRM_REG_ACC: rd_reg = {1'b1, q.acc};
			`MRM_REG_TRQ: rd_reg = {1'b1, q.trq};
			`MRM_REG_POS_ACT: rd_reg = {1'b1, m.pos_act};
			`MRM_REG_VEL_ACT: rd_reg = {1'b1, m.vel_act};
			`MRM_REG_LOAD: rd_reg = {1'b1, motor_load_i};
			`MRM_REG_FERR: rd_reg = {1'b1, m.ferr};
			`MRM_REG_STATUS: rd_reg = {1'b1, status_w};
			default: rd_reg = {1'b0, 32'h0000_0000};
		endcase
	endfunction : rd_reg

	function automatic logic is_wr(input logic [7:0] num);
		is_wr = (num == `MRM_REG_MODE) || (num == `MRM_REG_POS_SP)
			|| (num == `MRM_REG_VEL) || (num == `MRM_REG_ACC)
			|| (num == `MRM_REG_TRQ) || (num == `MRM_REG_CMD);
	endfunction : is_wr

	// write into a state copy; the command register only triggers
	function automatic mrm_pkg::mrm_top_st_t wr_reg(
		input mrm_pkg::mrm_top_st_t s, input logic [7:0] num,
		input logic [31:0] v);
		wr_reg = s;
		unique case (num)
			`MRM_REG_MODE: begin
				wr_reg.mode = v; // any mode write also acks the fault cause
				wr_reg.err = 8'h00;
			end
			`MRM_REG_POS_SP: wr_reg.pos = v;
			`MRM_REG_VEL: wr_reg.vel = v;
			`MRM_REG_ACC: wr_reg.acc = v;
			`MRM_REG_TRQ: wr_reg.trq = v;
			`MRM_REG_CMD: begin
				if (v == `MRM_CMD_SAVE) begin
					wr_reg.fsm = mrm_pkg::ST_SAVE_REQ;
					wr_reg.idx = 3'h0;
				end
			end
			default: wr_reg = s;
		endcase
	endfunction : wr_reg

	// flash slot mapping: one fixed set, no banks
	function automatic logic [31:0] get_cfg(input logic [2:0] i);
		unique case (i)
			`MRM_CFG_MODE: get_cfg = q.mode;
			`MRM_CFG_VEL: get_cfg = q.vel;
			`MRM_CFG_ACC: get_cfg = q.acc;
			`MRM_CFG_TRQ: get_cfg = q.trq;
			default: get_cfg = q.pos;
		endcase
	endfunction : get_cfg

	function automatic mrm_pkg::mrm_top_st_t put_cfg(
		input mrm_pkg::mrm_top_st_t s, input logic [2:0] i,
		input logic [31:0] v);
		put_cfg = s;
		unique case (i)
			`MRM_CFG_MODE: put_cfg.mode = v;
			`MRM_CFG_VEL: put_cfg.vel = v;
			`MRM_CFG_ACC: put_cfg.acc = v;
			`MRM_CFG_TRQ: put_cfg.trq = v;
			default: put_cfg.pos = v;
		endcase
	endfunction : put_cfg

	// ---------------------------------------------------------------
	// status word and cyclic read words
	// ---------------------------------------------------------------
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`MRM_ST_INPOS] = m.in_pos;
		status_w[`MRM_ST_ACCEL] = m.accel;
		status_w[`MRM_ST_DECEL] = m.decel;
		status_w[`MRM_ST_ERR_LSB +: 8] = q.err;
	end

	// a procedure per word, so the helper's internal reads retrigger it
	for (genvar g = 0; g < `MRM_CYC_N; g++) begin : g_cyc
		logic [32:0] rd_w;
		always_comb begin
			rd_w = rd_reg(CYC_RD_MAP[g*8 +: 8]);
		end
		assign cyc_rd_w[g] = rd_w[31:0];
	end

	// message decode: class, length and instance range first
	assign msg_ok = (msg_class_i == `MRM_CLASS_REG)
		&& (msg_len_i == `MRM_MSG_LEN) && (msg_instance_i[15:8] == 8'h00);
	// a procedure, not an assign: an assign would miss register changes
	always_comb begin
		msg_rd = rd_reg(msg_instance_i[7:0]);
	end
	assign msg_hit = msg_ok && (msg_write_i ? is_wr(msg_instance_i[7:0])
		: msg_rd[32]);
	assign msg_save = msg_valid_i && msg_hit && msg_write_i
		&& (msg_instance_i[7:0] == `MRM_REG_CMD)
		&& (msg_wdata_i == `MRM_CMD_SAVE);

	// ---------------------------------------------------------------
	// next state: boot load, run, save, self reset
	// ---------------------------------------------------------------
	always_comb begin
		n = q;
		n.rsp_valid = msg_valid_i; // every message answered next cycle
		n.rsp_error = 1'b1; // busy or refused unless run accepts it
		n.rsp_data = 32'h0000_0000;
		n.sys_rst = 1'b0;
		n.cyc_rd = cyc_rd_w;
		n.fwd_valid = p1_rx_valid_i && !p1_rx_local_i;
		n.fwd_data = p1_rx_data_i;
		n.trq_out = (q.trq > `MRM_TRQ_MAX) ? `MRM_TRQ_FULL : q.trq[9:0];
		unique case (q.fsm)
			mrm_pkg::ST_LOAD_REQ: begin
				n.fl_rd = 1'b1;
				n.fl_addr = q.idx;
				n.fsm = mrm_pkg::ST_LOAD_WAIT;
			end
			mrm_pkg::ST_LOAD_WAIT: begin
				if (flash_ack_i) begin
					n.fl_rd = 1'b0;
					n = put_cfg(n, q.idx, flash_rdata_i);
					n.idx = (q.idx == `MRM_CFG_LAST) ? 3'h0 : q.idx + 3'h1;
					n.fsm = (q.idx == `MRM_CFG_LAST) ? mrm_pkg::ST_RUN
						: mrm_pkg::ST_LOAD_REQ;
				end
			end
			mrm_pkg::ST_RUN: begin
				// cyclic first so a message in the same cycle wins
				if (cyc_wr_valid_i) begin
					for (int i = 0; i < `MRM_CYC_N; i++) begin
						if (is_wr(CYC_WR_MAP[i*8 +: 8])) begin
							n = wr_reg(n, CYC_WR_MAP[i*8 +: 8],
								cyc_wr_data_i[i*32 +: 32]);
						end
					end
				end
				if (msg_valid_i) begin
					n.rsp_error = !msg_hit;
					if (msg_hit && msg_write_i) begin
						n = wr_reg(n, msg_instance_i[7:0], msg_wdata_i);
					end else if (msg_hit) begin
						n.rsp_data = msg_rd[31:0];
					end
				end
			end
			mrm_pkg::ST_SAVE_REQ: begin
				n.fl_wr = 1'b1;
				n.fl_addr = q.idx;
				n.fl_wdata = get_cfg(q.idx);
				n.fsm = mrm_pkg::ST_SAVE_WAIT;
			end
			mrm_pkg::ST_SAVE_WAIT: begin
				if (flash_ack_i) begin
					n.fl_wr = 1'b0;
					n.idx = (q.idx == `MRM_CFG_LAST) ? 3'h0 : q.idx + 3'h1;
					n.fsm = (q.idx == `MRM_CFG_LAST) ? mrm_pkg::ST_RESET
						: mrm_pkg::ST_SAVE_REQ;
				end
			end
			mrm_pkg::ST_RESET: begin
				n.sys_rst = 1'b1;
				n.mode = `MRM_MODE_PASSIVE;
				n.err = 8'h00;
				n.idx = 3'h0;
				n.fsm = mrm_pkg::ST_LOAD_REQ;
			end
			default: begin
				n.fsm = mrm_pkg::ST_LOAD_REQ;
				n.idx = 3'h0;
			end
		endcase
		// fault beats any mode write and any cause clear in this cycle
		n.err = n.err | fault_i;
		if (fault_i != 8'h00) begin
			n.mode = `MRM_MODE_PASSIVE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// ---------------------------------------------------------------
	// profiler and outputs
	// ---------------------------------------------------------------
	// the drive only moves once the stored set is loaded
	assign m.enable = (q.mode != `MRM_MODE_PASSIVE)
		&& (q.fsm == mrm_pkg::ST_RUN);
	assign m.mode = q.mode;
	assign m.vel_sp = q.vel;
	assign m.acc_sp = q.acc;
	assign m.pos_sp = q.pos;

	mrm_motion u_motion (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.m(m)
	);

	assign rsp_valid_o = q.rsp_valid;
	assign rsp_error_o = q.rsp_error;
	assign rsp_rdata_o = q.rsp_data;
	assign cyc_rd_data_o = q.cyc_rd;
	assign drive_enable_o = m.drive_en;
	assign velocity_cmd_o = m.vel_act;
	assign torque_limit_o = q.trq_out;
	assign flash_rd_o = q.fl_rd;
	assign flash_wr_o = q.fl_wr;
	assign flash_addr_o = q.fl_addr;
	assign flash_wdata_o = q.fl_wdata;
	assign sys_reset_req_o = q.sys_rst;
	assign p2_tx_valid_o = q.fwd_valid;
	assign p2_tx_data_o = q.fwd_data;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_MODE_ZERO_OFF: assert property (
		q.mode == `MRM_MODE_PASSIVE |=> !drive_enable_o)
		else $error("drive enabled with mode zero");
	AST_POS_READ: assert property (
		(q.fsm == mrm_pkg::ST_RUN && msg_valid_i && msg_ok
		&& !msg_write_i && msg_instance_i[7:0] == `MRM_REG_POS_ACT)
		|=> rsp_rdata_o == $past(m.pos_act))
		else $error("position read mismatch");
	AST_STATUS_BITS: assert property (
		(q.fsm == mrm_pkg::ST_RUN && msg_valid_i && msg_ok
		&& !msg_write_i && msg_instance_i[7:0] == `MRM_REG_STATUS)
		|=> rsp_rdata_o[`MRM_ST_INPOS] == $past(m.in_pos)
		&& rsp_rdata_o[`MRM_ST_ACCEL] == $past(m.accel)
		&& rsp_rdata_o[`MRM_ST_DECEL] == $past(m.decel))
		else $error("status motion bits wrong");
	AST_FAULT_STOP: assert property (
		fault_i != 8'h00 |=> q.mode == `MRM_MODE_PASSIVE
		&& (q.err & $past(fault_i)) == $past(fault_i) ##1 !drive_enable_o)
		else $error("fault did not stop the motor");
	AST_BOOT_DONE: assert property (
		(q.fsm == mrm_pkg::ST_LOAD_WAIT && flash_ack_i
		&& q.idx == `MRM_CFG_LAST)
		|=> q.fsm == mrm_pkg::ST_RUN && q.pos == $past(flash_rdata_i))
		else $error("boot load did not finish");
	AST_LEN_CLASS: assert property (
		(msg_valid_i && (msg_len_i != `MRM_MSG_LEN
		|| msg_class_i != `MRM_CLASS_REG)) |=> rsp_valid_o && rsp_error_o)
		else $error("bad class or length accepted");
	AST_SAVE_RESET: assert property (
		(q.fsm == mrm_pkg::ST_RUN && msg_save && !cyc_wr_valid_i)
		|=> q.fsm == mrm_pkg::ST_SAVE_REQ
		##1 flash_wr_o && flash_addr_o == 3'h0)
		else $error("save command not started");
	AST_TRQ_CLAMP: assert property (
		q.trq > `MRM_TRQ_MAX |=> torque_limit_o == `MRM_TRQ_FULL)
		else $error("torque limit not clamped");
	AST_BAD_INST: assert property (
		(q.fsm == mrm_pkg::ST_RUN && msg_valid_i && msg_ok && msg_write_i
		&& !is_wr(msg_instance_i[7:0]) && !cyc_wr_valid_i
		&& fault_i == 8'h00) |=> rsp_error_o && $stable(q.mode)
		&& $stable(q.vel) && $stable(q.pos))
		else $error("unknown instance changed state");
	AST_FORWARD: assert property (
		(p1_rx_valid_i && !p1_rx_local_i)
		|=> p2_tx_valid_o && p2_tx_data_o == $past(p1_rx_data_i))
		else $error("downstream traffic not forwarded");
endmodule : mrm_top
`default_nettype wire

// ===== tb/mrm_flash_model.sv
// behavioural configuration flash answering the front end's slot requests
`timescale 1ns/1ps
`default_nettype none
module mrm_flash_model #(
	parameter int LAT = 2,
	parameter logic [159:0] INIT = '0
) (
	// clock
	input wire logic clk_sys_i,
	// request from the front end
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [2:0] addr_i,
	input wire logic [31:0] wdata_i,
	// answer
	output logic [31:0] rdata_o,
	output logic ack_o
);
	logic [4:0][31:0] mem_q;
	logic [3:0] cnt_q;

	// stored set at power-up
	initial begin
		mem_q = INIT;
		cnt_q = '0;
		ack_o = 1'b0;
	end

	// a slow answer; a write replaces the only stored set
	always @(posedge clk_sys_i) begin
		ack_o <= 1'b0;
		if (!(rd_i || wr_i) || ack_o) begin
			cnt_q <= '0;
		end else if (cnt_q == LAT[3:0]) begin
			ack_o <= 1'b1;
			cnt_q <= '0;
			if (wr_i) begin
				mem_q[addr_i] <= wdata_i;
			end
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// data valid only with ack; inverse otherwise so early sampling fails
	assign rdata_o = ack_o ? mem_q[addr_i] : ~mem_q[addr_i];
endmodule : mrm_flash_model
`default_nettype wire

// ===== tb/mrm_top_bench.sv
// self-checking bench of the motor register front end
`timescale 1ns/1ps
`default_nettype none
`include "mrm_map.svh"
module mrm_top_bench;
	localparam logic [159:0] BOOT = {32'd0, 32'd100, 32'd1, 32'd7, 32'd0};
	localparam logic [159:0] SAVE = {32'h33, 32'h400, 32'h22, 32'h11, 32'h0};
	localparam logic [39:0] SLOT_REG = 40'h03_0706_0502;
	localparam logic [95:0] BAD_CLS = {{5{16'h0064}}, 16'h0065};
	localparam logic [95:0] BAD_INST = {16'h00d3, 16'h0099, 16'h000a,
		16'h0105, 16'h0005, 16'h0005};
	localparam logic [47:0] BAD_LEN = {32'h0404_0404, 8'h02, 8'h04};
	localparam logic [5:0] BAD_WR = 6'b01_1111;
	logic clk_sys_i, rstn_i, msg_valid_i, msg_write_i;
	logic [15:0] msg_class_i, msg_instance_i;
	logic [7:0] msg_len_i, fault_i, p1_rx_data_i, p2_tx_data_o;
	logic [31:0] msg_wdata_i, rsp_rdata_o, motor_load_i, velocity_cmd_o;
	logic rsp_valid_o, rsp_error_o, cyc_wr_valid_i, drive_enable_o;
	logic [159:0] cyc_wr_data_i, cyc_rd_data_o;
	logic [9:0] torque_limit_o;
	logic flash_rd_o, flash_wr_o, flash_ack_i, sys_reset_req_o;
	logic [2:0] flash_addr_o;
	logic [31:0] flash_wdata_o, flash_rdata_i, seed, q, v, t;
	logic p1_rx_valid_i, p1_rx_local_i, p2_tx_valid_o, e;
	int num_errors, tests_run, i;

	mrm_top #(.CYC_WR_MAP(40'h02_0706_0503), .CYC_RD_MAP(40'h10_140c_230a))
	i_mrm_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.msg_valid_i(msg_valid_i), .msg_write_i(msg_write_i),
		.msg_class_i(msg_class_i), .msg_instance_i(msg_instance_i),
		.msg_len_i(msg_len_i), .msg_wdata_i(msg_wdata_i),
		.rsp_valid_o(rsp_valid_o), .rsp_error_o(rsp_error_o),
		.rsp_rdata_o(rsp_rdata_o), .cyc_wr_valid_i(cyc_wr_valid_i),
		.cyc_wr_data_i(cyc_wr_data_i), .cyc_rd_data_o(cyc_rd_data_o),
		.fault_i(fault_i), .motor_load_i(motor_load_i),
		.drive_enable_o(drive_enable_o), .velocity_cmd_o(velocity_cmd_o),
		.torque_limit_o(torque_limit_o), .flash_rd_o(flash_rd_o),
		.flash_wr_o(flash_wr_o), .flash_addr_o(flash_addr_o),
		.flash_wdata_o(flash_wdata_o), .flash_rdata_i(flash_rdata_i),
		.flash_ack_i(flash_ack_i), .sys_reset_req_o(sys_reset_req_o),
		.p1_rx_valid_i(p1_rx_valid_i), .p1_rx_data_i(p1_rx_data_i),
		.p1_rx_local_i(p1_rx_local_i), .p2_tx_valid_o(p2_tx_valid_o),
		.p2_tx_data_o(p2_tx_data_o));

	mrm_flash_model #(.LAT(2), .INIT(BOOT)) i_mrm_flash_model (
		.clk_sys_i(clk_sys_i), .rd_i(flash_rd_o), .wr_i(flash_wr_o),
		.addr_i(flash_addr_o), .wdata_i(flash_wdata_o),
		.rdata_o(flash_rdata_i), .ack_o(flash_ack_i));

	// --------------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task check(input string name, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : tick

	// one message held for its taking edge; the answer stands one cycle;
	// an idle cycle follows so the strobe never drops and rises at once
	task msg(input logic w, input logic [15:0] cls, inst,
		input logic [7:0] len, input logic [31:0] d);
		msg_valid_i = 1'b1;
		msg_write_i = w;
		msg_class_i = cls;
		msg_instance_i = inst;
		msg_len_i = len;
		msg_wdata_i = d;
		tick(1);
		msg_valid_i = 1'b0;
		e = rsp_error_o;
		q = rsp_rdata_o;
		check("rsp_valid", rsp_valid_o, 1);
		tick(1);
	endtask : msg

	task wr(input logic [15:0] inst, input logic [31:0] d);
		msg(1'b1, `MRM_CLASS_REG, inst, `MRM_MSG_LEN, d);
		check("wr_err", e, 0);
	endtask : wr

	task rd(input logic [15:0] inst);
		msg(1'b0, `MRM_CLASS_REG, inst, `MRM_MSG_LEN, 32'h0);
		check("rd_err", e, 0);
	endtask : rd

	// poll until the loaded set is in place; refused while loading
	task boot_wait;
		int k;
		e = 1'b1;
		for (k = 0; k < 100 && e !== 1'b0; k++) begin
			msg(1'b0, `MRM_CLASS_REG, 16'h0005, `MRM_MSG_LEN, 32'h0);
		end
		check("boot", e, 0);
	endtask : boot_wait

	task conclude;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	// --------------------------------------------------------------------
	// clock, watchdog, main sequence
	// --------------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// generous bound: the sequence needs a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		num_errors++;
		conclude();
	end

	initial begin
		{rstn_i, msg_valid_i, msg_write_i, msg_class_i, msg_instance_i} = '0;
		{msg_len_i, msg_wdata_i, cyc_wr_valid_i, cyc_wr_data_i} = '0;
		{fault_i, p1_rx_valid_i, p1_rx_data_i, p1_rx_local_i} = '0;
		num_errors = 0;
		tests_run = 0;
		seed = 32'hc52a;
		motor_load_i = 32'h0;
		tick(4);
		rstn_i = 1'b1;
		msg(1'b0, `MRM_CLASS_REG, 16'h0005, `MRM_MSG_LEN, 32'h0);
		check("early", e, 1);
		boot_wait();
		for (i = 0; i < 5; i++) begin
			rd({8'h00, SLOT_REG[i*8+:8]});
			check("boot_val", q, BOOT[i*32+:32]);
		end
		check("passive", drive_enable_o, 0);
		check("trq_boot", torque_limit_o, 10'd100);
		// refused messages leave the registers alone
		for (i = 0; i < 6; i++) begin
			msg(BAD_WR[i], BAD_CLS[i*16+:16], BAD_INST[i*16+:16],
				BAD_LEN[i*8+:8], 32'hdead_beef);
			check("refuse", e, 1);
			rd(16'h0005);
			check("kept", q, 32'd7);
		end
		// random words with torque corners around full scale
		for (i = 0; i < 9; i++) begin
			seed = lfsr(seed);
			t = 32'd5 + i % 3;
			v = (i < 6 && t == 32'd7) ? 32'h3ff + i / 3 : seed;
			wr(t[15:0], v);
			rd(t[15:0]);
			check("word", q, v);
			if (t == 32'd7) begin
				check("trq", torque_limit_o, (v > 32'h3ff) ? 10'h3ff : v[9:0]);
			end
		end
		motor_load_i = seed;
		rd(16'h0010);
		check("load", q, seed);
		// velocity mode ramps up, then down
		wr(16'h0005, 32'd20);
		wr(16'h0006, 32'd3);
		wr(16'h0002, `MRM_MODE_VEL);
		tick(1);
		check("active", drive_enable_o, 1);
		tick(2);
		rd(16'h0023);
		check("accel", q[`MRM_ST_ACCEL], 1);
		tick(20);
		check("vel_up", velocity_cmd_o, 32'd20);
		wr(16'h0005, 32'd2);
		tick(1);
		rd(16'h0023);
		check("decel", q[`MRM_ST_DECEL], 1);
		tick(10);
		check("vel_dn", velocity_cmd_o, 32'd2);
		// a fault stops the motor and shows its cause
		fault_i = 8'h05;
		tick(1);
		fault_i = 8'h00;
		tick(1);
		check("stop", drive_enable_o, 0);
		check("cyc_err", cyc_rd_data_o[47:40], 8'h05);
		rd(16'h0002);
		check("mode0", q, `MRM_MODE_PASSIVE);
		// position mode through the cyclic words
		rd(16'h000a);
		t = q + 32'd40;
		cyc_wr_data_i = {`MRM_MODE_POS, 32'd300, 32'd100, 32'd4, t};
		cyc_wr_valid_i = 1'b1;
		tick(1);
		cyc_wr_valid_i = 1'b0;
		for (i = 0; i < 500 && cyc_rd_data_o[36] !== 1'b1; i++) begin
			tick(1);
		end
		check("inpos", cyc_rd_data_o[36], 1);
		check("pos", cyc_rd_data_o[31:0], t);
		check("err_clr", cyc_rd_data_o[47:40], 8'h00);
		check("cyc_trq", torque_limit_o, 10'd300);
		check("cyc_load", cyc_rd_data_o[159:128], seed);
		cyc_wr_data_i[159:128] = `MRM_MODE_PASSIVE;
		cyc_wr_valid_i = 1'b1;
		tick(1);
		cyc_wr_valid_i = 1'b0;
		tick(1);
		check("cyc_stop", drive_enable_o, 0);
		// bytes for drives further down pass through, local ones do not
		p1_rx_valid_i = 1'b1;
		p1_rx_data_i = seed[7:0];
		tick(1);
		check("fwd", {p2_tx_valid_o, p2_tx_data_o}, {1'b1, seed[7:0]});
		p1_rx_local_i = 1'b1;
		tick(1);
		p1_rx_valid_i = 1'b0;
		check("local", p2_tx_valid_o, 0);
		// save, self-reset and reload the single stored set
		for (i = 1; i < 5; i++) begin
			wr({8'h00, SLOT_REG[i*8+:8]}, SAVE[i*32+:32]);
		end
		wr(16'h00d3, `MRM_CMD_SAVE);
		for (i = 0; i < 300 && sys_reset_req_o !== 1'b1; i++) begin
			tick(1);
		end
		check("self_rst", sys_reset_req_o, 1);
		boot_wait();
		for (i = 0; i < 5; i++) begin
			check("stored", i_mrm_flash_model.mem_q[i], SAVE[i*32+:32]);
			rd({8'h00, SLOT_REG[i*8+:8]});
			check("reload", q, SAVE[i*32+:32]);
		end
		check("trq_full", torque_limit_o, `MRM_TRQ_FULL);
		conclude();
	end
endmodule : mrm_top_bench
`default_nettype wire
